// ---- rtl/lecs_status_regs.sv ----
// Summary of operation
// RULE1 - Each lane's three-bit flag field sets when its counter reaches 0xFF.
// RULE2 - With hold enabled, a counter at 0xFF stays until software clears it.
// RULE3 - With hold disabled, a counter at 0xFF wraps to zero and keeps counting.
// RULE4 - Flag bit 2 control character, bit 1 not-in-table, bit 0 disparity.
// RULE5 - Bit 3 of each lane status register shows whether the lane is enabled.
// RULE6 - Lane status reflects the link picked by the page selector at 0x300.
// RULE7 - Lanes 4 to 6 status at 0x494 to 0x496, bits 7 to 4 read zero.
// RULE8 - Clearing an error counter also clears that counter's flag bit.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`include "lecs_params.svh"

module lecs_status_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [`LECS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [`LECS_BE_W-1:0] byteenable,
  input wire logic [`LECS_DATA_W-1:0] writedata,
  output logic [`LECS_DATA_W-1:0] readdata,
  output logic waitrequest,
  // Receiver lanes, indexed [link][lane]
  input wire lecs_pkg::lecs_link_cnt_t errEvent,
  input wire lecs_pkg::lecs_link_lane_t laneEnabled,
  // Interrupt
  output logic irq
);
  import lecs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lecs_regs_t regs_r;
  lecs_regs_t regs_nxt;
  logic [`LECS_IDX_W-1:0] regIdx;
  logic wrAccept;
  logic wrByte0;
  lecs_cnt_bits_t clearBits;
  lecs_link_cnt_t cntClear;
  lecs_link_cnt_t tcFlags;
  lecs_link_cnt_t tcHit;
  lecs_cnt_vals_t countValue [`LECS_NUM_LINKS][`LECS_NUM_LANES];
  lecs_lane_bits_t laneHit;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Status byte of one lane on the selected page
  function automatic logic [`LECS_DATA_W-1:0] lane_status(input int lane);
    logic [`LECS_DATA_W-1:0] w;
    w = `LECS_RST_WORD;
    w[`LECS_LANE_EN_BIT] = laneEnabled[regs_r.linkPage][lane]; // RULE5 RULE6
    w[`LECS_TC_MSB:0] = tcFlags[regs_r.linkPage][lane]; // RULE4 RULE6
    lane_status = w;
  endfunction

  // Packed counter values of one lane on the selected page
  function automatic logic [`LECS_DATA_W-1:0] lane_count(input int lane);
    logic [`LECS_DATA_W-1:0] w;
    lecs_cnt_vals_t v;
    w = `LECS_RST_WORD;
    v = countValue[regs_r.linkPage][lane];
    w[`LECS_CNT_W-1:0] = v[`LECS_DISPARITY_BIT];
    w[`LECS_CNT1_LSB +: `LECS_CNT_W] = v[`LECS_NOT_IN_TABLE_BIT];
    w[`LECS_CNT2_LSB +: `LECS_CNT_W] = v[`LECS_CTRL_CHAR_BIT];
    lane_count = w;
  endfunction

  // Read value for a register index; unmapped reads as zero
  function automatic logic [`LECS_DATA_W-1:0] reg_read(input logic [`LECS_IDX_W-1:0] idx);
    logic [`LECS_DATA_W-1:0] w;
    w = `LECS_RST_WORD;
    case (idx)
      `LECS_IDX_LINK_PAGE: begin
        w[`LECS_PAGE_BIT] = regs_r.linkPage;
      end
      `LECS_IDX_LANE4_STATUS: begin
        w = lane_status(0); // RULE7
      end
      `LECS_IDX_LANE5_STATUS: begin
        w = lane_status(1); // RULE7
      end
      `LECS_IDX_LANE6_STATUS: begin
        w = lane_status(2); // RULE7
      end
      `LECS_IDX_HOLD_CTRL: begin
        w[`LECS_TC_MSB:0] = regs_r.holdAtTerm;
      end
      `LECS_IDX_IRQ_STATUS: begin
        w[`LECS_NUM_LANES-1:0] = regs_r.irqStatus;
      end
      `LECS_IDX_IRQ_ENABLE: begin
        w[`LECS_NUM_LANES-1:0] = regs_r.irqEnable;
      end
      `LECS_IDX_LANE4_COUNT: begin
        w = lane_count(0);
      end
      `LECS_IDX_LANE5_COUNT: begin
        w = lane_count(1);
      end
      `LECS_IDX_LANE6_COUNT: begin
        w = lane_count(2);
      end
      default: begin
        w = `LECS_RST_WORD;
      end
    endcase
    reg_read = w;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Word index from byte address
  assign regIdx = address[`LECS_ADDR_W-1:`LECS_IDX_LSB];

  // Write takes effect in the cycle waitrequest is low
  assign wrAccept = write && (regs_r.busState == LECS_BUS_ACK);
  assign wrByte0 = wrAccept && byteenable[`LECS_WR_LANE];

  // One wait cycle for every request
  assign waitrequest = (read || write) && (regs_r.busState != LECS_BUS_ACK);

  // Counter clear strobe from the clear register
  always_comb begin
    clearBits = `LECS_RST_BITS3;
    if (wrByte0 && (regIdx == `LECS_IDX_CNT_CLEAR)) begin
      clearBits = writedata[`LECS_TC_MSB:0];
    end
  end

  // Clear only the counters of the selected link
  always_comb begin
    cntClear = '0;
    for (int k = 0; k < `LECS_NUM_LANES; k++) begin
      cntClear[regs_r.linkPage][k] = clearBits; // RULE6 RULE8
    end
  end

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // One counter set per lane per link
  for (genvar g = 0; g < `LECS_NUM_LINKS; g++) begin : gLink
    for (genvar l = 0; l < `LECS_NUM_LANES; l++) begin : gLane
      lecs_err_counter uCnt (
        .clk(clk),
        .rst_n(rst_n),
        .errEvent(errEvent[g][l]),
        .holdAtTerm(regs_r.holdAtTerm),
        .cntClear(cntClear[g][l]),
        .tcFlags(tcFlags[g][l]),
        .tcHit(tcHit[g][l]),
        .countValue(countValue[g][l])
      );
    end
  end

  // Terminal count reached on any link, per lane
  always_comb begin
    laneHit = '0;
    for (int g = 0; g < `LECS_NUM_LINKS; g++) begin
      for (int l = 0; l < `LECS_NUM_LANES; l++) begin
        laneHit[l] = laneHit[l] || (|tcHit[g][l]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    // Handshake and read capture
    case (regs_r.busState)
      LECS_BUS_IDLE: begin
        if (read || write) begin
          regs_nxt.busState = LECS_BUS_ACK;
        end
        if (read) begin
          regs_nxt.rdata = reg_read(regIdx);
        end
      end
      LECS_BUS_ACK: begin
        regs_nxt.busState = LECS_BUS_IDLE;
      end
      default: begin
        regs_nxt.busState = LECS_BUS_IDLE;
      end
    endcase
    // Writable controls
    if (wrByte0) begin
      case (regIdx)
        `LECS_IDX_LINK_PAGE: begin
          regs_nxt.linkPage = writedata[`LECS_PAGE_BIT]; // RULE6
        end
        `LECS_IDX_HOLD_CTRL: begin
          regs_nxt.holdAtTerm = writedata[`LECS_TC_MSB:0]; // RULE2 RULE3
        end
        `LECS_IDX_IRQ_ENABLE: begin
          regs_nxt.irqEnable = writedata[`LECS_NUM_LANES-1:0];
        end
        default: begin
          regs_nxt.linkPage = regs_r.linkPage;
        end
      endcase
    end
    // Sticky events, a new event beats the clear
    if (wrByte0 && (regIdx == `LECS_IDX_IRQ_CLEAR)) begin
      regs_nxt.irqStatus = regs_r.irqStatus & ~writedata[`LECS_NUM_LANES-1:0];
    end
    regs_nxt.irqStatus = regs_nxt.irqStatus | laneHit;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r.busState <= LECS_BUS_IDLE;
      regs_r.rdata <= `LECS_RST_WORD;
      regs_r.linkPage <= `LECS_RST_PAGE;
      regs_r.holdAtTerm <= `LECS_RST_BITS3;
      regs_r.irqStatus <= `LECS_RST_BITS3;
      regs_r.irqEnable <= `LECS_RST_BITS3;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readdata = regs_r.rdata;
  // Level interrupt from enabled sticky bits
  assign irq = |(regs_r.irqStatus & regs_r.irqEnable);

endmodule // lecs_status_regs

// ---- rtl/lecs_params.svh ----
`ifndef LECS_PARAMS_SVH
`define LECS_PARAMS_SVH

// ----------------------------------------------------------------
// Structure of the status bank
// ----------------------------------------------------------------
`define LECS_NUM_LINKS 2
`define LECS_NUM_LANES 3
`define LECS_NUM_CNT 3
`define LECS_CNT_W 8
`define LECS_DATA_W 32
`define LECS_ADDR_W 13
`define LECS_IDX_W 11
`define LECS_BE_W 4

// ----------------------------------------------------------------
// Counter values
// ----------------------------------------------------------------
`define LECS_TC_VALUE 8'hff
`define LECS_CNT_ZERO 8'h00
`define LECS_CNT_ONE 8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LECS_CTRL_CHAR_BIT 2
`define LECS_NOT_IN_TABLE_BIT 1
`define LECS_DISPARITY_BIT 0
`define LECS_LANE_EN_BIT 3
`define LECS_TC_MSB 2
`define LECS_PAGE_BIT 0
`define LECS_WR_LANE 0
`define LECS_IDX_LSB 2
`define LECS_CNT1_LSB 8
`define LECS_CNT2_LSB 16

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LECS_IDX_LINK_PAGE 11'h300
`define LECS_IDX_LANE4_STATUS 11'h494
`define LECS_IDX_LANE5_STATUS 11'h495
`define LECS_IDX_LANE6_STATUS 11'h496
`define LECS_IDX_HOLD_CTRL 11'h4a0
`define LECS_IDX_CNT_CLEAR 11'h4a1
`define LECS_IDX_IRQ_STATUS 11'h4a2
`define LECS_IDX_IRQ_CLEAR 11'h4a3
`define LECS_IDX_IRQ_ENABLE 11'h4a4
`define LECS_IDX_LANE4_COUNT 11'h4a8
`define LECS_IDX_LANE5_COUNT 11'h4a9
`define LECS_IDX_LANE6_COUNT 11'h4aa

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LECS_RST_WORD 32'h0000_0000
`define LECS_RST_BITS3 3'h0
`define LECS_RST_PAGE 1'h0

`endif

// ---- rtl/lecs_pkg.sv ----
package lecs_pkg;
  `include "lecs_params.svh"

  // One bit per error counter of a lane
  typedef logic [`LECS_NUM_CNT-1:0] lecs_cnt_bits_t;
  // One bit per lane
  typedef logic [`LECS_NUM_LANES-1:0] lecs_lane_bits_t;
  // Counter bits of every lane of every link
  typedef lecs_cnt_bits_t [`LECS_NUM_LINKS-1:0][`LECS_NUM_LANES-1:0] lecs_link_cnt_t;
  // Lane bits of every link
  typedef lecs_lane_bits_t [`LECS_NUM_LINKS-1:0] lecs_link_lane_t;
  // Values of the three counters of a lane
  typedef logic [`LECS_NUM_CNT-1:0][`LECS_CNT_W-1:0] lecs_cnt_vals_t;

  // Bus handshake states
  typedef enum logic [1:0] {
    LECS_BUS_IDLE = 2'b01,
    LECS_BUS_ACK = 2'b10
  } lecs_bus_state_t;

  // State of one lane's counter set
  typedef struct packed {
    lecs_cnt_vals_t count;
    lecs_cnt_bits_t tcFlags;
  } lecs_cnt_state_t;

  // State of the register bank
  typedef struct packed {
    lecs_bus_state_t busState;
    logic [`LECS_DATA_W-1:0] rdata;
    logic linkPage;
    lecs_cnt_bits_t holdAtTerm;
    lecs_lane_bits_t irqStatus;
    lecs_lane_bits_t irqEnable;
  } lecs_regs_t;

  // Counter increment
  function automatic logic [`LECS_CNT_W-1:0] lecs_inc(input logic [`LECS_CNT_W-1:0] v);
    lecs_inc = v + `LECS_CNT_ONE;
  endfunction

endpackage

// ---- rtl/lecs_err_counter.sv ----
`timescale 1ns/100ps
`include "lecs_params.svh"

module lecs_err_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Error events and controls
  input wire lecs_pkg::lecs_cnt_bits_t errEvent,
  input wire lecs_pkg::lecs_cnt_bits_t holdAtTerm,
  input wire lecs_pkg::lecs_cnt_bits_t cntClear,
  // Status
  output lecs_pkg::lecs_cnt_bits_t tcFlags,
  output lecs_pkg::lecs_cnt_bits_t tcHit,
  output lecs_pkg::lecs_cnt_vals_t countValue
);
  import lecs_pkg::*;

  lecs_cnt_state_t state_r;
  lecs_cnt_state_t state_nxt;

  // ----------------------------------------------------------------
  // Counter update
  // ----------------------------------------------------------------
  // Clear, count, hold or wrap for each counter
  always_comb begin
    state_nxt = state_r;
    tcHit = `LECS_RST_BITS3;
    for (int i = 0; i < `LECS_NUM_CNT; i++) begin
      if (cntClear[i]) begin
        // Clear drops the flag too; an event in that cycle counts once
        state_nxt.count[i] = errEvent[i] ? `LECS_CNT_ONE : `LECS_CNT_ZERO; // RULE2
        state_nxt.tcFlags[i] = 1'b0; // RULE8
      end else if (errEvent[i]) begin
        if (state_r.count[i] == `LECS_TC_VALUE) begin
          if (!holdAtTerm[i]) begin
            state_nxt.count[i] = `LECS_CNT_ZERO; // RULE3
          end
        end else begin
          state_nxt.count[i] = lecs_inc(state_r.count[i]);
          if (lecs_inc(state_r.count[i]) == `LECS_TC_VALUE) begin
            state_nxt.tcFlags[i] = 1'b1; // RULE1
            tcHit[i] = !state_r.tcFlags[i];
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs from flops
  assign tcFlags = state_r.tcFlags;
  assign countValue = state_r.count;

endmodule // lecs_err_counter

// ---- verification/lecs_status_sva.sv ----
`timescale 1ns/100ps
// ------------------------------
// Bus and status checker
// ------------------------------
module lecs_status_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic [12:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Lanes and interrupt
  input wire lecs_pkg::lecs_link_cnt_t errEvent,
  input wire lecs_pkg::lecs_link_lane_t laneEnabled,
  input wire logic irq
);
  import lecs_pkg::*;
  logic pageR;
  logic [10:0] idx;
  logic isStat;
  // Word index and status range
  assign idx = address[12:2];
  assign isStat = idx >= 11'h494 && idx <= 11'h496;
  // Shadow of the page selector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pageR <= 1'b0;
    end else if (write && !waitrequest && byteenable[0] && idx == 11'h300) begin
      pageR <= writedata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
  a_wait_idle_low: assert property (!read && !write |-> !waitrequest) else $error("wait while idle");
  a_ack_one_cycle: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write))
    else $error("ack too long");
  a_reserved_zero: assert property (read && !waitrequest && isStat |-> readdata[31:4] == 28'h0)
    else $error("reserved bits set");
  a_lane_enable_bit: assert property (read && waitrequest && isStat |=>
    readdata[3] == $past(laneEnabled[pageR][address[3:2]])) else $error("lane enable bit wrong");
  a_unmapped_zero: assert property (read && !waitrequest && (idx == 11'h497 || idx == 11'h4a1) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(|errEvent) || $past(write && !waitrequest))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(write && !waitrequest))
    else $error("irq fell without write");
  a_rdata_stable: assert property (!(read && waitrequest) |=> $stable(readdata)) else $error("readdata moved");
endmodule // lecs_status_sva

bind lecs_status_regs lecs_status_sva i_lecs_status_sva (.clk(clk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .errEvent(errEvent), .laneEnabled(laneEnabled), .irq(irq));

// ---- verification/lecs_status_regs_tb.sv ----
`timescale 1ns/100ps
module lecs_status_regs_tb;
  import lecs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] address = 13'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  lecs_link_cnt_t errEvent = '0;
  lecs_link_lane_t laneEnabled = '0;
  int err_total = 0;
  int num_checks = 0;
  int seed = 13;
  int irqSt = 0;
  int irqEn = 0;
  int hold = 0;
  int page = 0;
  int cnt [2][3][3];
  int flg [2][3][3];
  // Clock
  always #2 clk = ~clk;
  lecs_status_regs i_lecs_status_regs (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .errEvent(errEvent), .laneEnabled(laneEnabled), .irq(irq));
  // ------------------------------
  // Reporting
  // ------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ------------------------------
  // Bus master and model
  // ------------------------------
  task automatic xfer(input logic wr, input logic [10:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    // Let an edge pass so a release and a new request never share a time step
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    // Sample waitrequest and readdata at the rising edge itself
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [10:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
    case (idx)
      11'h300: page = d[0];
      11'h4a0: hold = d[2:0];
      11'h4a4: irqEn = d[2:0];
      11'h4a3: irqSt = irqSt & ~d[2:0];
      11'h4a1: for (int l = 0; l < 3; l++) for (int c = 0; c < 3; c++) if (d[c]) begin
        cnt[page][l][c] = 0;
        flg[page][l][c] = 0;
      end
      default: ;
    endcase
  endtask
  task automatic rd(input string what, input logic [10:0] idx, input int exp);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, q);
    check(what, q, exp);
  endtask
  // One error event on one counter
  function automatic void step(input int k, l, c);
    if (cnt[k][l][c] == 255) begin
      if (!hold[c]) cnt[k][l][c] = 0;
    end else begin
      cnt[k][l][c]++;
      if (cnt[k][l][c] == 255 && !flg[k][l][c]) irqSt |= 1 << l;
      if (cnt[k][l][c] == 255) flg[k][l][c] = 1;
    end
  endfunction
  task automatic pulse(input int n, input logic [17:0] mask);
    logic [17:0] ev;
    repeat (n) begin
      ev = $random(seed) & mask;
      errEvent <= ev;
      @(posedge clk);
      for (int k = 0; k < 18; k++) if (ev[k]) step(k / 9, (k / 3) % 3, k % 3);
    end
    errEvent <= '0;
  endtask
  // Read back every lane of both pages and the interrupt
  task automatic check_all(input string name);
    for (int p = 0; p < 2; p++) begin
      wr(11'h300, p);
      for (int l = 0; l < 3; l++) begin
        rd("status", 11'h494 + l, (laneEnabled[p][l] << 3) | (flg[p][l][2] << 2) | (flg[p][l][1] << 1) | flg[p][l][0]);
        rd("count", 11'h4a8 + l, (cnt[p][l][2] << 16) | (cnt[p][l][1] << 8) | cnt[p][l][0]);
      end
    end
    rd("irq status", 11'h4a2, irqSt);
    @(negedge clk);
    check("irq", irq, (irqSt & irqEn) != 0);
    @(posedge clk);
    $display("test %s done", name);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_all("reset");
    wr(11'h494, 32'hff);
    rd("read only", 11'h494, 0);
    rd("unmapped", 11'h497, 0);
    laneEnabled <= 6'($random(seed));
    wr(11'h4a4, 32'h7);
    check_all("lane enable");
    pulse(600, 18'h00054);
    check_all("wrap");
    wr(11'h4a0, 32'h7);
    pulse(600, 18'h3fe00);
    check_all("hold");
    wr(11'h300, 32'h1);
    wr(11'h4a1, 32'h2);
    wr(11'h4a3, 32'h1);
    check_all("clear");
    wr(11'h4a4, 32'h0);
    check_all("mask");
    end_of_test();
  end
endmodule // lecs_status_regs_tb
